// File: rtl/tpf_pkg.sv
//------------------------------------------------------------
// Behaviour
// - Channel A selector sits in bits 7:4, channel B in bits 3:0, active only with enable.
// - Code 0000 passes converted data, 0001 gives all zeros, 0010 gives all ones.
// - Code 0011 alternates 10101010101010 and its complement on successive samples.
// - Code 0100 gives a ramp rising by one each sample from zero to full scale.
// - Code 0101 gives the programmed custom word on every sample.
// - Code 0110 gives the deskew word 3aaa on every sample.
// - Code 1000 gives a new pseudo-random word every sample.
// - Code 1001 repeats 0, 2399, 8192, 13984, 16383, 13984, 8192, 2399.
// - Align bit 0 lets generators run free; 1 keeps all four channels in step.
// - Format bit 0 codes samples in two's complement, 1 in offset binary.
// - The global enable switches all outputs between normal data and patterns.
//------------------------------------------------------------
package tpf_pkg;

    localparam int DATA_W = 14;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BAND_C     = 8'h08;
    localparam logic [7:0] IDX_BAND_ALIGN = 8'h09;
    localparam logic [7:0] IDX_PAT_SEL    = 8'h0a;
    localparam logic [7:0] IDX_TP_CTRL    = 8'h0e;
    localparam logic [7:0] IDX_CUSTOM     = 8'h0f;
    localparam logic [7:0] IDX_STATUS     = 8'h10;

    // field positions
    localparam int BAND_LSB   = 2;
    localparam int ALIGN_BIT  = 1;
    localparam int FORMAT_BIT = 0;
    localparam int SEL_A_LSB  = 4;
    localparam int SEL_B_LSB  = 0;
    localparam int EN_BIT     = 0;

    // writable bits; the rest are fixed zero
    localparam logic [7:0]  MASK_BAND_C     = 8'h1c;
    localparam logic [7:0]  MASK_BAND_ALIGN = 8'h1f;
    localparam logic [7:0]  MASK_PAT_SEL    = 8'hff;
    localparam logic [7:0]  MASK_TP_CTRL    = 8'h01;
    localparam logic [15:0] MASK_CUSTOM     = 16'h3fff;

    // values after reset
    localparam logic [7:0]  RST_REG8   = 8'h00;
    localparam logic [13:0] RST_CUSTOM = 14'h0000;
    localparam logic [14:0] PRBS_SEED  = 15'h7fff;

    // selector codes
    localparam logic [3:0] PAT_NORMAL = 4'h0;
    localparam logic [3:0] PAT_ZEROS  = 4'h1;
    localparam logic [3:0] PAT_ONES   = 4'h2;
    localparam logic [3:0] PAT_TOGGLE = 4'h3;
    localparam logic [3:0] PAT_RAMP   = 4'h4;
    localparam logic [3:0] PAT_CUSTOM = 4'h5;
    localparam logic [3:0] PAT_DESKEW = 4'h6;
    localparam logic [3:0] PAT_PRBS   = 4'h8;
    localparam logic [3:0] PAT_SINE   = 4'h9;

    // pattern words
    localparam logic [13:0] TOGGLE_WORD = 14'h2aaa;
    localparam logic [13:0] DESKEW_WORD = 14'h3aaa;
    localparam logic [13:0] SINE_0      = 14'h0000;
    localparam logic [13:0] SINE_1      = 14'h095f;
    localparam logic [13:0] SINE_2      = 14'h2000;
    localparam logic [13:0] SINE_3      = 14'h36a0;
    localparam logic [13:0] SINE_4      = 14'h3fff;

    typedef struct packed {
        logic        enable;
        logic        align;
        logic        offset_bin;
        logic [3:0]  sel_a;
        logic [3:0]  sel_b;
        logic [13:0] custom;
    } tpf_cfg_t;

endpackage

// File: rtl/tpf_prbs.sv
//------------------------------------------------------------
// lfsr x^15 + x^14 + 1, advanced one word per clock
//------------------------------------------------------------
module tpf_prbs
#(
    parameter int WORD_W = 14
)
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    // control
    input  wire logic              i_restart,
    // word out
    output logic [WORD_W-1:0]      o_word
);

    logic [14:0] lfsr_q;
    logic [14:0] lfsr_d;

    if (WORD_W > 15)
    begin : g_chk
        $error("tpf_prbs: word wider than the lfsr");
    end

    // one shift per output bit so successive words do not overlap
    always_comb
    begin
        lfsr_d = lfsr_q;
        for (int i = 0; i < WORD_W; i++)
        begin
            lfsr_d = {lfsr_d[13:0], lfsr_d[14] ^ lfsr_d[13]};
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || i_restart)
            lfsr_q <= tpf_pkg::PRBS_SEED;
        else
            lfsr_q <= lfsr_d;
    end

    assign o_word = lfsr_q[WORD_W-1:0];

endmodule

// File: rtl/tpf_pattern_gen.sv
//------------------------------------------------------------
// one channel's pattern source
//------------------------------------------------------------
module tpf_pattern_gen
#(
    parameter int DATA_W = 14
)
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    // control
    input  wire logic              i_restart,
    input  wire logic [3:0]        i_sel,
    input  wire logic [DATA_W-1:0] i_custom,
    // pattern out
    output logic [DATA_W-1:0]      o_pattern,
    output logic [DATA_W-1:0]      o_ramp
);

    logic [DATA_W-1:0] ramp_q;
    logic              toggle_q;
    logic [2:0]        sine_q;
    logic [DATA_W-1:0] prbs_word;
    logic [DATA_W-1:0] sine_word;

    if (DATA_W != tpf_pkg::DATA_W)
    begin : g_chk
        $error("tpf_pattern_gen: pattern words are 14 bits");
    end

    tpf_prbs #(.WORD_W(DATA_W)) u_prbs
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_restart (i_restart),
        .o_word    (prbs_word)
    );

    // all sequences step every sample so a restart lines them up
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || i_restart)
        begin
            ramp_q   <= '0;
            toggle_q <= 1'b0;
            sine_q   <= '0;
        end
        else
        begin
            ramp_q   <= ramp_q + 1'b1;
            toggle_q <= ~toggle_q;
            sine_q   <= sine_q + 3'h1;
        end
    end

    assign sine_word = (sine_q == 3'h0) ? tpf_pkg::SINE_0 :
                       (sine_q == 3'h4) ? tpf_pkg::SINE_4 :
                       (sine_q[1:0] == 2'h2) ? tpf_pkg::SINE_2 :
                       (sine_q == 3'h3 || sine_q == 3'h5) ? tpf_pkg::SINE_3 :
                       tpf_pkg::SINE_1;

    // reserved codes give zeros
    assign o_pattern =
        (i_sel == tpf_pkg::PAT_ONES)   ? '1 :
        (i_sel == tpf_pkg::PAT_TOGGLE) ? (toggle_q ? ~tpf_pkg::TOGGLE_WORD
                                                   : tpf_pkg::TOGGLE_WORD) :
        (i_sel == tpf_pkg::PAT_RAMP)   ? ramp_q :
        (i_sel == tpf_pkg::PAT_CUSTOM) ? i_custom :
        (i_sel == tpf_pkg::PAT_DESKEW) ? tpf_pkg::DESKEW_WORD :
        (i_sel == tpf_pkg::PAT_PRBS)   ? prbs_word :
        (i_sel == tpf_pkg::PAT_SINE)   ? sine_word :
        '0;

    assign o_ramp = ramp_q;

endmodule

// File: rtl/tpf_formatter.sv
//------------------------------------------------------------
// test pattern and output format stage, channels a and b
//------------------------------------------------------------
module tpf_formatter
#(
    parameter int DATA_W = 14
)
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // converted samples, offset binary from the core
    input  wire logic [DATA_W-1:0] i_conv_a,
    input  wire logic [DATA_W-1:0] i_conv_b,
    // formatted samples
    output logic [DATA_W-1:0]      o_data_a,
    output logic [DATA_W-1:0]      o_data_b,
    // settings for the channel c and d paths
    output logic [2:0]             o_freq_band_cfg_c,
    output logic [2:0]             o_freq_band_cfg_d,
    output logic                   o_pattern_en,
    output logic                   o_pattern_align,
    output logic                   o_pattern_restart
);

    if (DATA_W != tpf_pkg::DATA_W)
    begin : g_chk
        $error("tpf_formatter: only 14-bit samples are served");
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    logic [7:0]        band_c_q;
    logic [7:0]        band_align_q;
    logic [7:0]        pat_sel_q;
    logic [7:0]        tp_ctrl_q;
    logic [13:0]       custom_q;
    logic              wait_q;
    logic [31:0]       rdata_q;

    tpf_pkg::tpf_cfg_t cfg;

    //------------------------------------------------------------
    // address decode
    //------------------------------------------------------------
    wire [7:0] addr_band_c     = {tpf_pkg::IDX_BAND_C[5:0], 2'b00};
    wire [7:0] addr_band_align = {tpf_pkg::IDX_BAND_ALIGN[5:0], 2'b00};
    wire [7:0] addr_pat_sel    = {tpf_pkg::IDX_PAT_SEL[5:0], 2'b00};
    wire [7:0] addr_tp_ctrl    = {tpf_pkg::IDX_TP_CTRL[5:0], 2'b00};
    wire [7:0] addr_custom     = {tpf_pkg::IDX_CUSTOM[5:0], 2'b00};
    wire [7:0] addr_status     = {tpf_pkg::IDX_STATUS[5:0], 2'b00};

    wire hit_band_c     = (i_avs_address == addr_band_c);
    wire hit_band_align = (i_avs_address == addr_band_align);
    wire hit_pat_sel    = (i_avs_address == addr_pat_sel);
    wire hit_tp_ctrl    = (i_avs_address == addr_tp_ctrl);
    wire hit_custom     = (i_avs_address == addr_custom);
    wire hit_status     = (i_avs_address == addr_status);

    // one wait cycle, then the request completes
    wire req     = i_avs_read | i_avs_write;
    wire accept  = req & wait_q;
    wire wr_fire = i_avs_write & ~wait_q;
    wire lane0   = wr_fire & i_avs_byteenable[0];
    wire lane1   = wr_fire & i_avs_byteenable[1];

    // masked write values keep fixed-zero bits at zero
    wire [7:0] wd0      = i_avs_writedata[7:0];
    wire [7:0] band_c_d = wd0 & tpf_pkg::MASK_BAND_C;
    wire [7:0] band_a_d = wd0 & tpf_pkg::MASK_BAND_ALIGN;
    wire [7:0] pat_d    = wd0 & tpf_pkg::MASK_PAT_SEL;
    wire [7:0] ctrl_d   = wd0 & tpf_pkg::MASK_TP_CTRL;
    wire [15:0] cust_w  = i_avs_writedata[15:0] & tpf_pkg::MASK_CUSTOM;

    //------------------------------------------------------------
    // configuration fields
    //------------------------------------------------------------
    assign cfg.enable     = tp_ctrl_q[tpf_pkg::EN_BIT];
    assign cfg.align      = band_align_q[tpf_pkg::ALIGN_BIT];
    assign cfg.offset_bin = band_align_q[tpf_pkg::FORMAT_BIT];
    assign cfg.sel_a      = pat_sel_q[tpf_pkg::SEL_A_LSB +: 4];
    assign cfg.sel_b      = pat_sel_q[tpf_pkg::SEL_B_LSB +: 4];
    assign cfg.custom     = custom_q;

    //------------------------------------------------------------
    // pattern restart and alignment
    //------------------------------------------------------------
    logic [3:0] sel_a_prev_q;
    logic [3:0] sel_b_prev_q;
    logic       align_prev_q;
    logic       en_prev_q;
    logic       restart_a_q;
    logic       restart_b_q;
    logic       restart_all_q;

    wire chg_a    = (cfg.sel_a != sel_a_prev_q);
    wire chg_b    = (cfg.sel_b != sel_b_prev_q);
    wire en_rise  = cfg.enable & ~en_prev_q;
    wire al_rise  = cfg.align & ~align_prev_q;
    wire any_chg  = chg_a | chg_b | en_rise | al_rise;

    // aligned: any change restarts every channel together;
    // free running: each channel restarts on its own selector change or on the enable rising
    wire restart_a_d = cfg.align ? any_chg : (chg_a | en_rise);
    wire restart_b_d = cfg.align ? any_chg : (chg_b | en_rise);
    wire restart_all = cfg.align & any_chg;

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            sel_a_prev_q  <= tpf_pkg::PAT_NORMAL;
            sel_b_prev_q  <= tpf_pkg::PAT_NORMAL;
            align_prev_q  <= 1'b0;
            en_prev_q     <= 1'b0;
            restart_a_q   <= 1'b0;
            restart_b_q   <= 1'b0;
            restart_all_q <= 1'b0;
        end
        else
        begin
            sel_a_prev_q  <= cfg.sel_a;
            sel_b_prev_q  <= cfg.sel_b;
            align_prev_q  <= cfg.align;
            en_prev_q     <= cfg.enable;
            restart_a_q   <= restart_a_d;
            restart_b_q   <= restart_b_d;
            restart_all_q <= restart_all;
        end
    end

    //------------------------------------------------------------
    // pattern sources
    //------------------------------------------------------------
    logic [DATA_W-1:0] pat_a;
    logic [DATA_W-1:0] pat_b;
    logic [DATA_W-1:0] ramp_a;

    tpf_pattern_gen #(.DATA_W(DATA_W)) u_gen_a
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_restart (restart_a_q),
        .i_sel     (cfg.sel_a),
        .i_custom  (cfg.custom),
        .o_pattern (pat_a),
        .o_ramp    (ramp_a)
    );

    tpf_pattern_gen #(.DATA_W(DATA_W)) u_gen_b
    (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_restart (restart_b_q),
        .i_sel     (cfg.sel_b),
        .i_custom  (cfg.custom),
        .o_pattern (pat_b),
        .o_ramp    ()
    );

    //------------------------------------------------------------
    // output selection and coding
    //------------------------------------------------------------
    // core delivers offset binary; two's complement flips the msb.
    // patterns bypass the coder so their words stay as defined.
    wire [DATA_W-1:0] fmt_a = cfg.offset_bin ? i_conv_a
                            : {~i_conv_a[DATA_W-1], i_conv_a[DATA_W-2:0]};
    wire [DATA_W-1:0] fmt_b = cfg.offset_bin ? i_conv_b
                            : {~i_conv_b[DATA_W-1], i_conv_b[DATA_W-2:0]};

    wire use_pat_a = cfg.enable & (cfg.sel_a != tpf_pkg::PAT_NORMAL);
    wire use_pat_b = cfg.enable & (cfg.sel_b != tpf_pkg::PAT_NORMAL);

    wire [DATA_W-1:0] data_a_d = use_pat_a ? pat_a : fmt_a;
    wire [DATA_W-1:0] data_b_d = use_pat_b ? pat_b : fmt_b;

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            o_data_a          <= '0;
            o_data_b          <= '0;
            o_freq_band_cfg_c <= '0;
            o_freq_band_cfg_d <= '0;
            o_pattern_en      <= 1'b0;
            o_pattern_align   <= 1'b0;
            o_pattern_restart <= 1'b0;
        end
        else
        begin
            o_data_a          <= data_a_d;
            o_data_b          <= data_b_d;
            o_freq_band_cfg_c <= band_c_q[tpf_pkg::BAND_LSB +: 3];
            o_freq_band_cfg_d <= band_align_q[tpf_pkg::BAND_LSB +: 3];
            o_pattern_en      <= cfg.enable;
            o_pattern_align   <= cfg.align;
            o_pattern_restart <= restart_all_q;
        end
    end

    //------------------------------------------------------------
    // register writes
    //------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            band_c_q     <= tpf_pkg::RST_REG8;
            band_align_q <= tpf_pkg::RST_REG8;
            pat_sel_q    <= tpf_pkg::RST_REG8;
            tp_ctrl_q    <= tpf_pkg::RST_REG8;
        end
        else if (lane0)
        begin
            if (hit_band_c)
                band_c_q <= band_c_d;
            if (hit_band_align)
                band_align_q <= band_a_d;
            if (hit_pat_sel)
                pat_sel_q <= pat_d;
            if (hit_tp_ctrl)
                tp_ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            custom_q <= tpf_pkg::RST_CUSTOM;
        else if (hit_custom)
        begin
            if (lane0)
                custom_q[7:0] <= cust_w[7:0];
            if (lane1)
                custom_q[13:8] <= cust_w[13:8];
        end
    end

    //------------------------------------------------------------
    // read path and handshake
    //------------------------------------------------------------
    // status shows what each channel is actually putting out
    wire [31:0] status_w = {2'b00, ramp_a, 12'h000,
                            cfg.align, use_pat_b, use_pat_a, cfg.enable};

    // unmapped addresses read zero and ignore writes
    wire [31:0] rd_mux =
        hit_band_c     ? {24'h000000, band_c_q} :
        hit_band_align ? {24'h000000, band_align_q} :
        hit_pat_sel    ? {24'h000000, pat_sel_q} :
        hit_tp_ctrl    ? {24'h000000, tp_ctrl_q} :
        hit_custom     ? {18'h00000, custom_q} :
        hit_status     ? status_w :
        32'h00000000;

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end
        else
        begin
            wait_q <= ~accept;
            if (accept && i_avs_read)
                rdata_q <= rd_mux;
        end
    end

    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata    = rdata_q;

endmodule

// File: test/tpf_rx_model.sv
//------------------------------------------------------------
// far side: link receiver capturing one word a lane per clock
//------------------------------------------------------------
module tpf_rx_model
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // lanes from the formatter
    input  wire logic [13:0] i_data_a,
    input  wire logic [13:0] i_data_b,
    // captured words
    output logic [13:0]      o_rx_a,
    output logic [13:0]      o_rx_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // a real receiver latches every sample; it never holds back the stream
    always_ff @(posedge i_mclk)
    begin
        o_rx_a <= i_sys_rst ? 14'h0000 : i_data_a;
        o_rx_b <= i_sys_rst ? 14'h0000 : i_data_b;
    end
endmodule

// File: test/tpf_formatter_monitor.sv
//------------------------------------------------------------
// port checker for the formatter
//------------------------------------------------------------
module tpf_monitor
#(
    parameter int DATA_W = 14
)
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    // bus
    input  wire logic [7:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    input  wire logic [31:0]       o_avs_readdata,
    input  wire logic              o_avs_waitrequest,
    // samples
    input  wire logic [DATA_W-1:0] i_conv_a,
    input  wire logic [DATA_W-1:0] i_conv_b,
    input  wire logic [DATA_W-1:0] o_data_a,
    input  wire logic [DATA_W-1:0] o_data_b,
    // settings
    input  wire logic [2:0]        o_freq_band_cfg_c,
    input  wire logic [2:0]        o_freq_band_cfg_d,
    input  wire logic              o_pattern_en,
    input  wire logic              o_pattern_align,
    input  wire logic              o_pattern_restart
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] sa_q;
    logic [3:0] sb_q;
    logic       fmt_q;
    logic [2:0] cnt_q;
    wire        wdone = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    wire        rdone = i_avs_read && !o_avs_waitrequest;
    // pattern checks wait out the restart settling after any write
    wire        quiet = (cnt_q == 3'h7);

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || wdone)
            cnt_q <= 3'h0;
        else if (!quiet)
            cnt_q <= cnt_q + 3'h1;
        if (i_sys_rst)
            {sa_q, sb_q, fmt_q} <= 9'h000;
        else if (wdone && i_avs_address == 8'h28)
            {sa_q, sb_q} <= i_avs_writedata[7:0];
        else if (wdone && i_avs_address == 8'h24)
            fmt_q <= i_avs_writedata[0];
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus answer late");
    AST_WAIT_PULSE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low too long");
    AST_ZERO_A: assert property (o_pattern_en && sa_q == tpf_pkg::PAT_ZEROS && quiet
        |-> o_data_a == '0) else $error("zeros pattern wrong");
    AST_ONES_B: assert property ((o_pattern_en && sb_q == tpf_pkg::PAT_ONES && quiet)[*2]
        |-> o_data_b == '1) else $error("ones pattern wrong");
    AST_DESKEW_A: assert property (o_pattern_en && sa_q == tpf_pkg::PAT_DESKEW && quiet
        |-> o_data_a == tpf_pkg::DESKEW_WORD) else $error("deskew word wrong");
    AST_TOGGLE_A: assert property (o_pattern_en && sa_q == tpf_pkg::PAT_TOGGLE && quiet
        |-> o_data_a == ~$past(o_data_a)) else $error("toggle wrong");
    AST_RAMP_A: assert property (o_pattern_en && sa_q == tpf_pkg::PAT_RAMP && quiet
        |-> o_data_a == $past(o_data_a) + 14'h0001) else $error("ramp step wrong");
    AST_NORMAL_TC: assert property (!o_pattern_en && !fmt_q && quiet
        |-> o_data_a == {~$past(i_conv_a[DATA_W-1]), $past(i_conv_a[DATA_W-2:0])})
        else $error("twos complement data wrong");
    AST_NORMAL_OB: assert property (!o_pattern_en && fmt_q && quiet
        |-> o_data_b == $past(i_conv_b)) else $error("offset binary data wrong");
    AST_ALIGN: assert property (o_pattern_align && o_pattern_en && quiet
        && sa_q == sb_q && sa_q == tpf_pkg::PAT_RAMP |-> o_data_a == o_data_b)
        else $error("aligned channels differ");
    AST_FIXED0: assert property (rdone && i_avs_address == 8'h20
        |-> o_avs_readdata[31:5] == '0 && o_avs_readdata[1:0] == 2'h0)
        else $error("fixed bits not zero");
    AST_UNMAPPED: assert property (rdone && i_avs_address == 8'h04
        |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");

    cover property (o_pattern_en && sa_q == tpf_pkg::PAT_RAMP && quiet);
    cover property (o_pattern_align && o_pattern_restart);
    cover property (rdone && i_avs_address == 8'h28);
endmodule

bind tpf_formatter tpf_monitor #(.DATA_W(DATA_W)) mon
(
    .i_mclk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_conv_a, .i_conv_b,
    .o_data_a, .o_data_b, .o_freq_band_cfg_c, .o_freq_band_cfg_d, .o_pattern_en,
    .o_pattern_align, .o_pattern_restart
);

// File: test/tb_quad_channel_test_pattern_formatter.sv
module tb_quad_channel_test_pattern_formatter;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic [13:0] i_conv_a = 14'h1234;
    logic [13:0] i_conv_b = 14'h0abc;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [13:0] o_data_a, o_data_b, rx_a, rx_b;
    logic [2:0]  o_freq_band_cfg_c, o_freq_band_cfg_d;
    logic        o_pattern_en, o_pattern_align, o_pattern_restart;
    int          fails = 0;
    int          checked = 0;
    int          j;
    logic [13:0] s [0:16];
    logic [31:0] q;
    logic [7:0]  ta [0:4] = '{8'h20, 8'h24, 8'h24, 8'h28, 8'h04};
    logic [7:0]  tw [0:4] = '{8'hff, 8'hff, 8'h08, 8'h96, 8'hff};
    logic [7:0]  te [0:4] = '{8'h1c, 8'h1f, 8'h08, 8'h96, 8'h00};
    logic [3:0]  pc [0:3] = '{4'h1, 4'h2, 4'h5, 4'h6};
    logic [13:0] pe [0:3] = '{14'h0000, 14'h3fff, 14'h1357, tpf_pkg::DESKEW_WORD};
    logic [3:0]  sq [0:3] = '{4'h3, 4'h4, 4'h9, 4'h8};
    logic [13:0] sine [0:7] = '{tpf_pkg::SINE_0, tpf_pkg::SINE_1, tpf_pkg::SINE_2,
        tpf_pkg::SINE_3, tpf_pkg::SINE_4, tpf_pkg::SINE_3, tpf_pkg::SINE_2, tpf_pkg::SINE_1};

    tpf_formatter #(.DATA_W(14)) dut
    (
        .i_mclk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_conv_a, .i_conv_b,
        .o_data_a, .o_data_b, .o_freq_band_cfg_c, .o_freq_band_cfg_d, .o_pattern_en,
        .o_pattern_align, .o_pattern_restart
    );

    tpf_rx_model rx
    (
        .i_mclk, .i_sys_rst, .i_data_a(o_data_a), .i_data_b(o_data_b),
        .o_rx_a(rx_a), .o_rx_b(rx_b)
    );

    initial
        forever #2 i_mclk = ~i_mclk;

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // called just after a rising edge; outputs read here still hold pre-edge values
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (o_avs_waitrequest !== 1'b0 && n < 50);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            close_out();
        end
        @(posedge i_mclk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    initial
    begin
        tick(16);
        i_sys_rst <= 1'b0;
        tick(1);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b0, 8'h20 + 8'(4 * k), 32'h0, q);
            chk(q, 32'h0);
        end
        for (int k = 0; k < 5; k++)
        begin
            bus(1'b1, ta[k], {24'h0, tw[k]}, q);
            bus(1'b0, ta[k], 32'h0, q);
            chk(q, {24'h0, te[k]});
        end
        chk(o_freq_band_cfg_c, 3'h7);
        chk(o_freq_band_cfg_d, 3'h2);
        $display("test registers done");
        // selectors still hold codes, but the enable is off
        tick(8);
        chk(rx_a, 14'h3234);
        chk(rx_b, 14'h2abc);
        bus(1'b1, 8'h24, 32'h09, q);
        tick(8);
        chk(rx_a, 14'h1234);
        chk(rx_b, 14'h0abc);
        bus(1'b1, 8'h24, 32'h08, q);
        $display("test normal data done");
        bus(1'b1, 8'h38, 32'h1, q);
        bus(1'b1, 8'h3c, 32'h1357, q);
        chk(o_pattern_en, 1'b1);
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, 8'h28, (k < 4) ? {pc[k % 4], 4'h0} : {4'h0, pc[k % 4]}, q);
            tick(8);
            chk((k < 4) ? rx_a : rx_b, pe[k % 4]);
            chk((k < 4) ? rx_b : rx_a, (k < 4) ? 14'h2abc : 14'h3234);
        end
        $display("test fixed patterns done");
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, 8'h28, {sq[k], 4'h0}, q);
            tick(4);
            for (int i = 0; i < 17; i++)
            begin
                @(posedge i_mclk);
                s[i] = rx_a;
            end
            j = 0;
            while (j < 8 && s[j] !== 14'h0)
                j++;
            for (int i = 0; i < 8; i++)
                case (k)
                    0: chk({s[i], s[i + 1]}, s[i][13] ? 28'haaa9555 : 28'h5556aaa);
                    1: chk(s[i + 1], 14'(s[i] + 14'h1));
                    2: chk(s[j + i], sine[i]);
                    default: chk(s[i + 1] != s[i], 1'b1);
                endcase
            if (k == 0)
                j = 1;
            $display("test sequence %0d done", k);
        end
        bus(1'b1, 8'h28, 32'h40, q);
        j = 0;
        while (rx_a !== 14'h3fff && j < 20000)
        begin
            @(posedge i_mclk);
            j++;
        end
        if (j >= 20000)
        begin
            fails++;
            close_out();
        end
        @(posedge i_mclk);
        chk(rx_a, 14'h0000);
        bus(1'b1, 8'h28, 32'h44, q);
        tick(8);
        chk(rx_a != rx_b, 1'b1);
        bus(1'b1, 8'h24, 32'h0a, q);
        tick(2);
        chk(o_pattern_restart, 1'b1);
        tick(6);
        chk(o_pattern_align, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge i_mclk);
            chk(rx_a, rx_b);
        end
        bus(1'b1, 8'h38, 32'h0, q);
        tick(8);
        chk(rx_a, 14'h3234);
        $display("test align and wrap done");
        close_out();
    end
endmodule
